// File: hcp_ctrl_pins.sv
module hcp_ctrl_pins #(
  parameter int NUM_OUT = hcp_pkg::NUM_OUT,
  parameter int STAT_W = hcp_pkg::STAT_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  input wire logic i2c_sel_i,
  input wire logic [2:0] pin_undriven_i,
  input wire logic sdio_i,
  input wire logic addr_sel_hi_i,
  input wire logic addr_sel_lo_i,
  input wire logic device_reset_n_i,
  input wire logic out_gate0_n_i,
  input wire logic out_gate1_n_i,
  input wire logic spi_3wire_i,
  input wire logic [STAT_W-1:0] status_i,
  input wire logic irq_clear_i,
  input wire logic mask_load_i,
  input wire logic [NUM_OUT-1:0] gate0_mask_i,
  input wire logic [NUM_OUT-1:0] gate1_mask_i,
  input wire logic [hcp_pkg::BYTE_W-1:0] rd_data_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic addr_sel_hi_o,
  output logic addr_sel_hi_oe_o,
  output logic irq_n_o,
  output logic [NUM_OUT-1:0] clk_out_en_o,
  output logic dev_rst_o,
  output logic i2c_mode_o,
  output logic i2c_addressed_o,
  output logic [hcp_pkg::BYTE_W-1:0] rx_byte_o,
  output logic rx_valid_o
);
  import hcp_pkg::*;

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_BUSY, I2C_SKIP} hcp_i2c_st_t;

  typedef struct packed {
    logic sel_s1, sel_s2, lo_s1, lo_s2, hi_s1, hi_s2, rst_s1, rst_s2;
    logic g0_s1, g0_s2, g1_s1, g1_s2, sda_s1, sda_s2, scl_s1, scl_s2;
    logic sda_d, scl_d, tog_s1, tog_s2, tog_d;
    logic in_rst;
    logic i2c_mode;
    logic [NUM_OUT-1:0] clk_en;
    logic [NUM_OUT-1:0] g0_mask;
    logic [NUM_OUT-1:0] g1_mask;
    logic [STAT_W-1:0] stat_d;
    logic irq_n;
    hcp_i2c_st_t ist;
    logic [3:0] bit_cnt;
    logic [BYTE_W-1:0] shreg;
    logic ack_oe;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_vld;
    logic [BYTE_W-1:0] rd_snap;
  } hcp_state_t;

  hcp_state_t st_r, st_nxt;

  logic frame_rst;
  logic [BYTE_W-1:0] spi_rx_byte;
  logic spi_rx_tog;
  logic spi_sdio, spi_sdio_oe, spi_sdo, spi_sdo_oe;
  logic sel_raw, lo_raw, rst_raw;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;

  ////////////////////////////////////////////////////////////////
  // Pad pull-ups: an undriven pin reads high
  // Select defaults high
  assign sel_raw = i2c_sel_i | pin_undriven_i[UNDRV_SEL];
  assign lo_raw = addr_sel_lo_i | pin_undriven_i[UNDRV_LO];
  assign rst_raw = device_reset_n_i | pin_undriven_i[UNDRV_RST];

  // Raw pin values steer the link frame; an async clear needs no sync
  // Select gates frame
  assign frame_rst = lo_raw | sel_raw;

  ////////////////////////////////////////////////////////////////
  // Link side for SPI on the host's clock
  hcp_spi_link u_spi (
    .sclk_i(sclk_i),
    .frame_rst_i(frame_rst),
    .three_wire_i(spi_3wire_i),
    .sdi_i(sdio_i),
    .rd_data_i(st_r.rd_snap),
    .rx_byte_o(spi_rx_byte),
    .rx_tog_o(spi_rx_tog),
    .sdio_o(spi_sdio),
    .sdio_oe_o(spi_sdio_oe),
    .sdo_o(spi_sdo),
    .sdo_oe_o(spi_sdo_oe)
  );

  // I2C line events, oversampled from synchronised copies
  assign scl_rise = st_r.scl_s2 & ~st_r.scl_d;
  assign scl_fall = ~st_r.scl_s2 & st_r.scl_d;
  assign i2c_start = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
  assign i2c_stop = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Two-flop synchronisers on every pin
    st_nxt.sel_s1 = sel_raw;
    st_nxt.sel_s2 = st_r.sel_s1;
    st_nxt.lo_s1 = lo_raw;
    st_nxt.lo_s2 = st_r.lo_s1;
    st_nxt.hi_s1 = addr_sel_hi_i;
    st_nxt.hi_s2 = st_r.hi_s1;
    st_nxt.rst_s1 = rst_raw;
    st_nxt.rst_s2 = st_r.rst_s1;
    st_nxt.g0_s1 = out_gate0_n_i;
    st_nxt.g0_s2 = st_r.g0_s1;
    st_nxt.g1_s1 = out_gate1_n_i;
    st_nxt.g1_s2 = st_r.g1_s1;
    st_nxt.sda_s1 = sdio_i;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.scl_s1 = sclk_i;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.tog_s1 = spi_rx_tog;
    st_nxt.tog_s2 = st_r.tog_s1;
    st_nxt.sda_d = st_r.sda_s2;
    st_nxt.scl_d = st_r.scl_s2;
    st_nxt.tog_d = st_r.tog_s2;
    st_nxt.rx_vld = 1'b0;

    st_nxt.in_rst = ~st_r.rst_s2;
    st_nxt.i2c_mode = (st_r.sel_s2 == MODE_I2C);

    // Gate masks: defaults until software loads new ones
    if (mask_load_i) begin
      st_nxt.g0_mask = gate0_mask_i;
      st_nxt.g1_mask = gate1_mask_i;
    end

    st_nxt.clk_en = ~(({NUM_OUT{st_r.g0_s2}} & st_r.g0_mask) | ({NUM_OUT{st_r.g1_s2}} & st_r.g1_mask));
    if (st_r.in_rst) begin
      st_nxt.clk_en = '0;
    end

    st_nxt.stat_d = status_i;
    if (irq_clear_i) begin
      st_nxt.irq_n = 1'b1;
    end
    // A change in the clearing cycle wins over the clear
    if (status_i != st_r.stat_d) begin
      st_nxt.irq_n = 1'b0;
    end

    // Readback snapshot moves only between SPI frames, so the link sees it still
    if (st_r.lo_s2) begin
      st_nxt.rd_snap = rd_data_i;
      st_nxt.tog_d = st_r.tog_s2;
    end else if (st_r.tog_s2 != st_r.tog_d) begin
      // Byte is stable for eight link clocks, far longer than the toggle path
      st_nxt.rx_byte = spi_rx_byte;
      st_nxt.rx_vld = ~st_r.i2c_mode;
    end

    // I2C address phase
    case (st_r.ist)
      I2C_IDLE: begin
        st_nxt.ack_oe = 1'b0;
      end
      I2C_ADDR: begin
        if (scl_rise) begin
          st_nxt.shreg = {st_r.shreg[BYTE_W-2:0], st_r.sda_s2};
          st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end
        if (scl_fall && st_r.bit_cnt == I2C_ADDR_BITS) begin
          if (st_r.shreg[BYTE_W-1:1] == {I2C_BASE_ADDR[6:2], st_r.hi_s2, st_r.lo_s2}) begin
            st_nxt.ist = I2C_ACK;
            st_nxt.ack_oe = 1'b1;
          end else begin
            st_nxt.ist = I2C_SKIP;
          end
        end
      end
      I2C_ACK: begin
        if (scl_fall) begin
          st_nxt.ack_oe = 1'b0;
          st_nxt.ist = I2C_BUSY;
        end
      end
      I2C_BUSY: begin
        st_nxt.ack_oe = 1'b0;
      end
      I2C_SKIP: begin
        st_nxt.ack_oe = 1'b0;
      end
      default: begin
        st_nxt.ist = I2C_IDLE;
        st_nxt.ack_oe = 1'b0;
      end
    endcase
    // Start and stop override any phase; not active outside I2C mode
    if (i2c_start && st_r.i2c_mode) begin
      st_nxt.ist = I2C_ADDR;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.ack_oe = 1'b0;
    end else if (i2c_stop || !st_r.i2c_mode) begin
      st_nxt.ist = I2C_IDLE;
      st_nxt.ack_oe = 1'b0;
    end

    // Defaults return on either reset, pins keep sampling
    if (sys_rst_i || st_r.in_rst) begin
      st_nxt.g0_mask = {NUM_OUT{GATE0_MASK_RST}};
      st_nxt.g1_mask = {NUM_OUT{GATE1_MASK_RST}};
      st_nxt.irq_n = IRQ_N_RST;
      st_nxt.ist = I2C_IDLE;
      st_nxt.ack_oe = 1'b0;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.rx_vld = 1'b0;
      st_nxt.rx_byte = BYTE_RST;
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register; second stages of the lower address and reset synchronisers start high, the other synchroniser flops low
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.in_rst <= 1'b1;
      st_r.irq_n <= IRQ_N_RST;
      st_r.ist <= I2C_IDLE;
      st_r.g0_mask <= {NUM_OUT{GATE0_MASK_RST}};
      st_r.g1_mask <= {NUM_OUT{GATE1_MASK_RST}};
      st_r.lo_s2 <= 1'b1;
      st_r.rst_s2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  // Shared data pin owner
  assign sdio_o = st_r.i2c_mode ? 1'b0 : spi_sdio;
  assign sdio_oe_o = st_r.i2c_mode ? st_r.ack_oe : spi_sdio_oe;
  assign addr_sel_hi_o = spi_sdo;
  assign addr_sel_hi_oe_o = spi_sdo_oe & ~st_r.i2c_mode;
  assign irq_n_o = st_r.irq_n;
  assign clk_out_en_o = st_r.clk_en;
  assign dev_rst_o = st_r.in_rst;
  assign i2c_mode_o = st_r.i2c_mode;
  assign i2c_addressed_o = (st_r.ist == I2C_ACK) || (st_r.ist == I2C_BUSY);
  assign rx_byte_o = st_r.rx_byte;
  assign rx_valid_o = st_r.rx_vld;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_mode_follows_pin;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $changed(st_r.sel_s2) |=> (i2c_mode_o == $past(st_r.sel_s2));
  endproperty
  a_mode_follows_pin: assert property (p_mode_follows_pin) else $error("Mode did not follow select");

  property p_undriven_sel_i2c;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      pin_undriven_i[UNDRV_SEL] [*4] |-> i2c_mode_o;
  endproperty
  a_undriven_sel_i2c: assert property (p_undriven_sel_i2c) else $error("Undriven select not I2C");

  property p_irq_on_change;
    @(posedge sys_clk_i) disable iff (sys_rst_i || dev_rst_o)
      (status_i != st_r.stat_d) |=> !irq_n_o;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change) else $error("Status change missed");

  property p_reset_defaults;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      dev_rst_o |=> irq_n_o && (st_r.g0_mask == {NUM_OUT{GATE0_MASK_RST}}) && (st_r.g1_mask == '0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("Defaults not restored");

  property p_outputs_off_in_reset;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      dev_rst_o |=> (clk_out_en_o == '0);
  endproperty
  a_outputs_off_in_reset: assert property (p_outputs_off_in_reset) else $error("Clock enabled in reset");

  property p_undriven_rst_runs;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      pin_undriven_i[UNDRV_RST] [*4] |-> !dev_rst_o;
  endproperty
  a_undriven_rst_runs: assert property (p_undriven_rst_runs) else $error("Undriven reset held device");

  property p_gate0_disables;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_r.g0_s2 && !dev_rst_o) |=> ((clk_out_en_o & $past(st_r.g0_mask)) == '0);
  endproperty
  a_gate0_disables: assert property (p_gate0_disables) else $error("Gate zero failed to disable");

  property p_gate0_all_after_reset;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(dev_rst_o) |-> (st_r.g0_mask == {NUM_OUT{1'b1}});
  endproperty
  a_gate0_all_after_reset: assert property (p_gate0_all_after_reset) else $error("Gate zero not global");

  property p_gate1_inert;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_r.g1_mask == '0 && !st_r.g0_s2 && !dev_rst_o) |=> (clk_out_en_o == {NUM_OUT{1'b1}});
  endproperty
  a_gate1_inert: assert property (p_gate1_inert) else $error("Gate one acted unconfigured");

  property p_ack_needs_match;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(st_r.ack_oe) |-> $past(st_r.shreg[BYTE_W-1:1]) == {I2C_BASE_ADDR[6:2], st_r.hi_s2, st_r.lo_s2};
  endproperty
  a_ack_needs_match: assert property (p_ack_needs_match) else $error("Acked wrong address");

  c_i2c_ack: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(i2c_addressed_o));
  c_spi_byte: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) rx_valid_o);
  c_irq: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $fell(irq_n_o));
endmodule

// File: hcp_pkg.sv
// Contract
// - Select pin high I2C, low SPI
// - Undriven select pin reads high, I2C
// - Data pin: I2C, 3-wire bidir, 4-wire input
// - Upper address pin: I2C address, SPI output
// - Serial clock always an input from host
// - Lower address pin: I2C address, SPI select
// - Undriven lower address pin reads high
// - Interrupt output low on status change
// - Reset input low restores all defaults
// - Clock outputs disabled while in reset
// - Undriven reset input reads high
// - Gate zero low enables, high disables
// - Gate zero controls all outputs after reset
// - Gate one controls nothing until configured
package hcp_pkg;
  // Default counts
  localparam int NUM_OUT = 8;
  localparam int STAT_W = 8;
  localparam int BYTE_W = 8;
  // Undriven-pin flag positions
  localparam int UNDRV_SEL = 0;
  localparam int UNDRV_LO = 1;
  localparam int UNDRV_RST = 2;
  // Pin levels
  localparam logic MODE_I2C = 1'b1;
  localparam logic MODE_SPI = 1'b0;
  // I2C framing
  localparam logic [3:0] I2C_ADDR_BITS = 4'h8;
  localparam logic [6:0] I2C_BASE_ADDR = 7'h6c; // Arbitrary upper address bits
  // SPI framing: bit 7 of the command byte marks a read
  localparam int SPI_RD_BIT = 7;
  // Reset values
  localparam logic IRQ_N_RST = 1'b1;
  localparam logic GATE0_MASK_RST = 1'b1;
  localparam logic GATE1_MASK_RST = 1'b0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
endpackage

// File: hcp_spi_link.sv
module hcp_spi_link (
  input wire logic sclk_i,
  input wire logic frame_rst_i,
  input wire logic three_wire_i,
  input wire logic sdi_i,
  input wire logic [hcp_pkg::BYTE_W-1:0] rd_data_i,
  output logic [hcp_pkg::BYTE_W-1:0] rx_byte_o,
  output logic rx_tog_o,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  import hcp_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic [BYTE_W-1:0] sh;
    logic cmd_done;
    logic rd_cmd;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_tog;
  } hcp_rx_t;

  typedef struct packed {
    logic [BYTE_W-1:0] tx_sh;
    logic drive;
  } hcp_tx_t;

  hcp_rx_t rx_r, rx_nxt;
  hcp_tx_t tx_r, tx_nxt;

  ////////////////////////////////////////////////////////////////
  // Receive side, data taken on the rising edge
  // Host clocks shifting
  always_comb begin
    rx_nxt = rx_r;
    rx_nxt.sh = {rx_r.sh[BYTE_W-2:0], sdi_i};
    rx_nxt.cnt = rx_r.cnt + 3'h1;
    if (rx_r.cnt == 3'h7) begin
      rx_nxt.rx_byte = {rx_r.sh[BYTE_W-2:0], sdi_i};
      rx_nxt.rx_tog = ~rx_r.rx_tog;
      rx_nxt.cmd_done = 1'b1;
      // First byte decides read or write for the frame
      if (!rx_r.cmd_done) begin
        rx_nxt.rd_cmd = rx_r.sh[SPI_RD_BIT-1];
      end
    end
  end

  // Frame reset is the deselect level, so no state leaks between frames
  always_ff @(posedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Transmit side, launched on the falling edge for a full half period of setup
  always_comb begin
    tx_nxt = tx_r;
    tx_nxt.tx_sh = {tx_r.tx_sh[BYTE_W-2:0], 1'b0};
    if (rx_r.cmd_done && rx_r.rd_cmd && rx_r.cnt == 3'h0) begin
      tx_nxt.tx_sh = rd_data_i;
      tx_nxt.drive = 1'b1;
    end
  end

  always_ff @(negedge sclk_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      tx_r <= '0;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  // Data pin driven only in 3-wire reads
  assign sdio_o = tx_r.tx_sh[BYTE_W-1];
  assign sdio_oe_o = tx_r.drive & three_wire_i;
  // Upper address pin is output in 4-wire
  assign sdo_o = tx_r.tx_sh[BYTE_W-1];
  assign sdo_oe_o = tx_r.drive & ~three_wire_i;
  assign rx_byte_o = rx_r.rx_byte;
  assign rx_tog_o = rx_r.rx_tog;

  ////////////////////////////////////////////////////////////////
  // Checks in the link domain
  property p_spi_no_drive_before_cmd;
    @(posedge sclk_i) disable iff (frame_rst_i)
      !rx_r.cmd_done |-> !(sdio_oe_o || sdo_oe_o);
  endproperty
  a_spi_no_drive_before_cmd: assert property (p_spi_no_drive_before_cmd) else $error("SPI drove before command");

  property p_spi_one_driver;
    @(posedge sclk_i) disable iff (frame_rst_i)
      !(sdio_oe_o && sdo_oe_o);
  endproperty
  a_spi_one_driver: assert property (p_spi_one_driver) else $error("SPI drove both data pins");

  c_spi_read: cover property (@(posedge sclk_i) disable iff (frame_rst_i) rx_r.rd_cmd && tx_r.drive);
endmodule

// File: hcp_host_model.sv
module hcp_host_model (
  output logic sclk_o,
  output logic sd_d_o,
  output logic sd_oe_o,
  output logic lo_o,
  output logic hi_o,
  input wire logic sd_w_i,
  input wire logic hi_w_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: clock parked, data released, device deselected
  initial begin
    sclk_o = 1'b0;
    sd_d_o = 1'b1;
    sd_oe_o = 1'b0;
    lo_o = 1'b1;
    hi_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // SPI frame of two bytes, MSB first, 48 ns bit period
  // host clocks, selects low
  task automatic spi_xfer(input logic four, input logic rd, input logic [15:0] tx, output logic [7:0] rx);
    sclk_o = 1'b0;
    #24 lo_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sd_d_o = tx[i];
      sd_oe_o = four || !rd || i > 7; // Let go for 3-wire read data
      #24 sclk_o = 1'b1;
      if (i < 8) begin
        rx[i] = four ? hi_w_i : sd_w_i;
      end
      #24 sclk_o = 1'b0;
    end
    #24 lo_o = 1'b1;
    sd_oe_o = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  // I2C start and address byte; open drain, so only low is driven
  // host supplies the clock
  task automatic i2c_addr(input logic a1, input logic a0, input logic [7:0] byte_v, output logic ack);
    hi_o = a1;
    lo_o = a0;
    sd_d_o = 1'b0;
    sd_oe_o = 1'b0;
    sclk_o = 1'b1;
    #48 sd_oe_o = 1'b1;
    #24 sclk_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #12 sd_oe_o = !byte_v[i];
      #12 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    #12 sd_oe_o = 1'b0;
    #12 sclk_o = 1'b1;
    ack = !sd_w_i;
    #24 sclk_o = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic i2c_stop;
    #24 sd_oe_o = 1'b1;
    #24 sclk_o = 1'b1;
    #24 sd_oe_o = 1'b0;
    #48;
  endtask
endmodule

// File: hcp_ctrl_pins_test.sv
module hcp_ctrl_pins_test;
  import hcp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, sel, g0_n, g1_n, rst_n, three, irq_clr, mask_ld;
  logic [2:0] undrv;
  logic [7:0] status, m0, m1, rd_data, rx, rx_last, rx_byte, en;
  logic h_sclk, h_d, h_oe, h_lo, h_hi, sd_w, hi_w, sd_o, sd_oe, hi_o, hi_oe;
  logic irq_n, dev_rst, i2c_mode, addressed, rx_valid, ack;
  int err_total, comparisons, cycles, rx_cnt, n0;

  // Wire levels: I2C data has a pull-up, released SPI data shows the inverse
  assign sd_w = sd_oe ? sd_o : h_oe ? h_d : sel ? 1'b1 : ~h_d;
  assign hi_w = hi_oe ? hi_o : h_hi;

  hcp_ctrl_pins hcp_ctrl_pins_i (
    .sys_clk_i(clk), .sys_rst_i(rst), .sclk_i(h_sclk), .i2c_sel_i(sel), .pin_undriven_i(undrv),
    .sdio_i(sd_w), .addr_sel_hi_i(hi_w), .addr_sel_lo_i(h_lo), .device_reset_n_i(rst_n),
    .out_gate0_n_i(g0_n), .out_gate1_n_i(g1_n), .spi_3wire_i(three), .status_i(status),
    .irq_clear_i(irq_clr), .mask_load_i(mask_ld), .gate0_mask_i(m0), .gate1_mask_i(m1),
    .rd_data_i(rd_data), .sdio_o(sd_o), .sdio_oe_o(sd_oe), .addr_sel_hi_o(hi_o),
    .addr_sel_hi_oe_o(hi_oe), .irq_n_o(irq_n), .clk_out_en_o(en), .dev_rst_o(dev_rst),
    .i2c_mode_o(i2c_mode), .i2c_addressed_o(addressed), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid)
  );

  hcp_host_model hcp_host_model_i (
    .sclk_o(h_sclk), .sd_d_o(h_d), .sd_oe_o(h_oe), .lo_o(h_lo), .hi_o(h_hi),
    .sd_w_i(sd_w), .hi_w_i(hi_w)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Received bytes and the hang guard; ceiling far above the roughly 1200 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_byte;
    end
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic close_out;
    $display("Counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, sel, rst_n, g0_n, g1_n, three, irq_clr, mask_ld} = 8'he0;
    {undrv, status, m0, m1, rd_data} = '0;
    cyc(4);
    rst <= 1'b0;
    cyc(6);
    // Gate pins and their masks
    chk_byte("en_default", 8'hff, en);
    g1_n <= 1'b1;
    cyc(5);
    chk_byte("en_gate1_free", 8'hff, en);
    g0_n <= 1'b1;
    cyc(5);
    chk_byte("en_gate0_high", 8'h00, en);
    {m0, m1, mask_ld} <= {8'hf0, 8'h0c, 1'b1};
    cyc(1);
    mask_ld <= 1'b0;
    cyc(4);
    chk_byte("en_subsets", 8'h03, en);
    g0_n <= 1'b0;
    cyc(5);
    chk_byte("en_gate1_subset", 8'hf3, en);
    $display("Test gates finished");
    // Interrupt set, clear, set again
    status <= 8'h01;
    cyc(4);
    chk_bit("irq_set", 1'b0, irq_n);
    irq_clr <= 1'b1;
    cyc(1);
    irq_clr <= 1'b0;
    cyc(3);
    chk_bit("irq_clear", 1'b1, irq_n);
    status <= 8'h03;
    cyc(4);
    chk_bit("irq_again", 1'b0, irq_n);
    $display("Test interrupt finished");
    // Device reset pin: defaults come back, outputs held off
    rst_n <= 1'b0;
    cyc(6);
    chk_bit("dev_rst_on", 1'b1, dev_rst);
    chk_bit("irq_in_reset", 1'b1, irq_n);
    chk_byte("en_in_reset", 8'h00, en);
    rst_n <= 1'b1;
    cyc(8);
    chk_bit("dev_rst_off", 1'b0, dev_rst);
    chk_byte("en_masks_default", 8'hff, en);
    {undrv[2], rst_n} <= 2'b10;
    cyc(6);
    chk_bit("rst_floating", 1'b0, dev_rst);
    {undrv[2], rst_n} <= 2'b01;
    $display("Test device reset finished");
    // Mode strap, driven and floating
    sel <= MODE_SPI;
    cyc(4);
    chk_bit("mode_spi", MODE_SPI, i2c_mode);
    undrv[0] <= 1'b1;
    cyc(4);
    chk_bit("mode_floating", MODE_I2C, i2c_mode);
    undrv[0] <= 1'b0;
    rd_data <= 8'ha5;
    cyc(4);
    chk_bit("mode_spi_back", MODE_SPI, i2c_mode);
    // SPI: 4-wire write and read, 3-wire read, floating select
    n0 = rx_cnt;
    hcp_host_model_i.spi_xfer(1'b1, 1'b0, 16'h123c, rx);
    cyc(10);
    chk_byte("spi_bytes", 8'h02, 8'(rx_cnt - n0));
    chk_byte("spi_wr_byte", 8'h3c, rx_last);
    hcp_host_model_i.spi_xfer(1'b1, 1'b1, 16'h8000, rx);
    chk_byte("spi4_rd", 8'ha5, rx);
    cyc(2);
    chk_bit("sdo_released", 1'b0, hi_oe);
    three <= 1'b1;
    cyc(2);
    hcp_host_model_i.spi_xfer(1'b0, 1'b1, 16'h8000, rx);
    chk_byte("spi3_rd", 8'ha5, rx);
    undrv[1] <= 1'b1;
    cyc(2);
    n0 = rx_cnt;
    hcp_host_model_i.spi_xfer(1'b1, 1'b0, 16'h1234, rx);
    cyc(10);
    chk_byte("spi_floating_cs", 8'h00, 8'(rx_cnt - n0));
    undrv[1] <= 1'b0;
    $display("Test spi finished");
    // I2C address match on the two pins, then a mismatch
    sel <= MODE_I2C;
    cyc(4);
    hcp_host_model_i.i2c_addr(1'b1, 1'b0, {I2C_BASE_ADDR[6:2], 3'b100}, ack);
    chk_bit("i2c_ack", 1'b1, ack);
    chk_bit("i2c_addressed", 1'b1, addressed);
    hcp_host_model_i.i2c_stop();
    chk_bit("i2c_stop_idle", 1'b0, addressed);
    hcp_host_model_i.i2c_addr(1'b1, 1'b1, {I2C_BASE_ADDR[6:2], 3'b100}, ack);
    chk_bit("i2c_no_ack", 1'b0, ack);
    chk_bit("i2c_not_addressed", 1'b0, addressed);
    hcp_host_model_i.i2c_stop();
    $display("Test i2c finished");
    close_out();
  end
endmodule
